// ---- verilog/pll_damping_gain_config.sv ----
// Damping and low-frequency gain configuration for the two loops.
// Assumes an APB master on mclk and bandwidth/mode inputs from mclk logic.
// Operation
// - The applied damping factor comes from the code, and for codes 4 and 5 also from the bandwidth now in force.
// - Gain peak follows the factor: 0.4, 0.2, 0.1, 0.06, 0.03 dB for 1.2, 2.5, 5, 10, 20.
// - Bits 6 to 4 of the damping register hold the analog gain for references at or below 8 kHz.
// - That gain field applies only while bit 7 of the loop's gain register enables automatic selection.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module pll_damping_gain_config (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pll_damp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0][1:0] loop_bandwidth,
    input wire logic [1:0] analog_feedback,
    input wire logic [1:0] ref_at_or_below_8k,
    output logic [1:0][7:0] damping_factor,
    output logic [1:0][7:0] gain_peak,
    output logic [1:0] damping_reserved,
    output logic [1:0][2:0] lowfreq_gain,
    output logic [1:0] lowfreq_gain_active
);
    import pll_damp_pkg::*;

    // Index 0 is the first loop, index 1 the second
    logic [1:0][7:0] damp_ff;
    logic [1:0] gain_en_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic access;
    logic hit_first_damp;
    logic hit_second_damp;
    logic hit_first_gain;
    logic hit_second_gain;

    // Word decode; low address bits must be zero
    assign hit_first_damp = (paddr == ADDR_FIRST_DAMP);
    assign hit_second_damp = (paddr == ADDR_SECOND_DAMP);
    assign hit_first_gain = (paddr == ADDR_FIRST_GAIN);
    assign hit_second_gain = (paddr == ADDR_SECOND_GAIN);
    assign access = psel && penable && pready_ff;

    // Read mux; unmapped addresses read zero and flag an error
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        if (hit_first_damp) begin
            nxt_prdata = {24'h00_0000, damp_ff[0]};
        end else if (hit_second_damp) begin
            nxt_prdata = {24'h00_0000, damp_ff[1]};
        end else if (hit_first_gain) begin
            nxt_prdata = {24'h00_0000, gain_en_ff[0], 7'h00};
        end else if (hit_second_gain) begin
            nxt_prdata = {24'h00_0000, gain_en_ff[1], 7'h00};
        end else begin
            nxt_pslverr = 1'b1;
        end
    end

    // One wait-free access cycle: ready rises for the access phase only
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= psel && !penable;
            pslverr_ff <= psel && !penable && nxt_pslverr;
            if (psel && !penable && !pwrite) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    // Damping registers; unused bits are masked off on write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            damp_ff[0] <= DAMP_RST;
            damp_ff[1] <= DAMP_RST;
        end else if (access && pwrite) begin
            if (hit_first_damp) begin
                damp_ff[0] <= pwdata[7:0] & DAMP_WMASK;
            end
            if (hit_second_damp) begin
                damp_ff[1] <= pwdata[7:0] & DAMP_WMASK;
            end
        end
    end

    // Automatic gain selection enables
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gain_en_ff <= {GAIN_EN_RST, GAIN_EN_RST};
        end else if (access && pwrite) begin
            if (hit_first_gain) begin
                gain_en_ff[0] <= pwdata[GAIN_EN_BIT];
            end
            if (hit_second_gain) begin
                gain_en_ff[1] <= pwdata[GAIN_EN_BIT];
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    // Per-loop lookup and registered loop settings
    for (genvar i = 0; i < 2; i++) begin : g_loop
        damp_lookup_if lk ();
        logic [7:0] factor_ff;
        logic [7:0] peak_ff;
        logic reserved_ff;
        logic [2:0] lfgain_ff;
        logic lfactive_ff;
        logic nxt_lfactive;

        assign lk.code = damp_ff[i][CODE_LSB +: 3];
        assign lk.bw = loop_bandwidth[i];

        damp_lookup u_lookup (
            .lk(lk)
        );

        // Gain field only counts in analog mode at low reference rate
        assign nxt_lfactive = gain_en_ff[i] && analog_feedback[i]
            && ref_at_or_below_8k[i];

        // Registered so the loop sees stable settings
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                factor_ff <= 8'h00;
                peak_ff <= 8'h00;
                reserved_ff <= 1'b0;
                lfgain_ff <= 3'h0;
                lfactive_ff <= 1'b0;
            end else begin
                factor_ff <= lk.factor;
                peak_ff <= lk.peak;
                reserved_ff <= lk.reserved;
                lfactive_ff <= nxt_lfactive;
                lfgain_ff <= nxt_lfactive
                    ? damp_ff[i][LFGAIN_LSB +: 3] : 3'h0;
            end
        end

        assign damping_factor[i] = factor_ff;
        assign gain_peak[i] = peak_ff;
        assign damping_reserved[i] = reserved_ff;
        assign lowfreq_gain[i] = lfgain_ff;
        assign lowfreq_gain_active[i] = lfactive_ff;
    end
endmodule
`default_nettype wire

// ---- verilog/pll_damp_pkg.sv ----
// Constants for the loop damping and gain configuration registers.
// Assumes a 32-bit APB register bus with one aligned word per register.
package pll_damp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SECOND_DAMP = 8'h6A;
    localparam logic [7:0] IDX_FIRST_DAMP = 8'h6B;
    localparam logic [7:0] IDX_SECOND_GAIN = 8'h6C;
    localparam logic [7:0] IDX_FIRST_GAIN = 8'h6D;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_SECOND_DAMP = {2'h0, IDX_SECOND_DAMP, 2'h0};
    localparam logic [11:0] ADDR_FIRST_DAMP = {2'h0, IDX_FIRST_DAMP, 2'h0};
    localparam logic [11:0] ADDR_SECOND_GAIN = {2'h0, IDX_SECOND_GAIN, 2'h0};
    localparam logic [11:0] ADDR_FIRST_GAIN = {2'h0, IDX_FIRST_GAIN, 2'h0};

    // Damping register layout
    localparam int CODE_LSB = 0;
    localparam int LFGAIN_LSB = 4;
    localparam logic [7:0] DAMP_WMASK = 8'h77;
    localparam logic [7:0] DAMP_RST = 8'h13;
    // Gain register: only the automatic selection enable is held here
    localparam int GAIN_EN_BIT = 7;
    localparam logic GAIN_EN_RST = 1'b1;

    // Loop bandwidth codes as the rest of the unit delivers them
    localparam logic [1:0] BW_18HZ = 2'h3;
    localparam logic [1:0] BW_35HZ = 2'h0;
    localparam logic [1:0] BW_70HZ = 2'h1;

    // Damping factor in tenths
    localparam logic [7:0] DF_1P2 = 8'h0C;
    localparam logic [7:0] DF_2P5 = 8'h19;
    localparam logic [7:0] DF_5 = 8'h32;
    localparam logic [7:0] DF_10 = 8'h64;
    localparam logic [7:0] DF_20 = 8'hC8;
    // Gain peak in hundredths of a dB
    localparam logic [7:0] GP_1P2 = 8'h28;
    localparam logic [7:0] GP_2P5 = 8'h14;
    localparam logic [7:0] GP_5 = 8'h0A;
    localparam logic [7:0] GP_10 = 8'h06;
    localparam logic [7:0] GP_20 = 8'h03;

endpackage

// ---- verilog/damp_lookup_if.sv ----
// Carries one loop's damping code and bandwidth to the lookup and back.
// Assumes the lookup is purely combinational on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface damp_lookup_if;
    logic [2:0] code;
    logic [1:0] bw;
    logic [7:0] factor;
    logic [7:0] peak;
    logic reserved;
    modport cfg (output code, output bw, input factor, input peak,
        input reserved);
    modport lookup (input code, input bw, output factor, output peak,
        output reserved);
endinterface
`default_nettype wire

// ---- verilog/damp_lookup.sv ----
// Maps a damping code and loop bandwidth to damping factor and gain peak.
// Assumes registered use of its outputs by the instantiating block.
`timescale 1ns/100ps
`default_nettype none
module damp_lookup (
    damp_lookup_if.lookup lk
);
    import pll_damp_pkg::*;

    // Factor depends on the bandwidth in force for codes 4 and 5
    always_comb begin
        lk.factor = 8'h00;
        lk.reserved = 1'b0;
        unique case (lk.code)
            3'h1: lk.factor = DF_1P2;
            3'h2: lk.factor = DF_2P5;
            3'h3: lk.factor = DF_5;
            3'h4: begin
                if (lk.bw == BW_18HZ) begin
                    lk.factor = DF_5;
                end else if (lk.bw == BW_35HZ || lk.bw == BW_70HZ) begin
                    lk.factor = DF_10;
                end else begin
                    lk.reserved = 1'b1; // Unused bandwidth code
                end
            end
            3'h5: begin
                if (lk.bw == BW_18HZ) begin
                    lk.factor = DF_5;
                end else if (lk.bw == BW_35HZ) begin
                    lk.factor = DF_10;
                end else if (lk.bw == BW_70HZ) begin
                    lk.factor = DF_20;
                end else begin
                    lk.reserved = 1'b1;
                end
            end
            default: lk.reserved = 1'b1; // 000, 110, 111
        endcase
    end

    // Gain peak follows the chosen factor
    always_comb begin
        unique case (lk.factor)
            DF_1P2: lk.peak = GP_1P2;
            DF_2P5: lk.peak = GP_2P5;
            DF_5: lk.peak = GP_5;
            DF_10: lk.peak = GP_10;
            DF_20: lk.peak = GP_20;
            default: lk.peak = 8'h00;
        endcase
    end
endmodule
`default_nettype wire

// ---- verification/pll_damping_gain_config_properties.sv ----
// Checker for the loop damping configuration block, bound to its top.
// Assumes one clock domain, mclk, with nrst as its asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module pll_damping_gain_config_checker
    import pll_damp_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pll_damp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [1:0][1:0] loop_bandwidth,
    input wire logic [1:0] analog_feedback,
    input wire logic [1:0] ref_at_or_below_8k,
    input wire logic [1:0][7:0] damping_factor,
    input wire logic [1:0][7:0] gain_peak,
    input wire logic [1:0] damping_reserved,
    input wire logic [1:0][2:0] lowfreq_gain,
    input wire logic [1:0] lowfreq_gain_active
);
    // All checks share one clock and one reset
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    reserved_zero_a: assert property (damping_reserved[1] |->
        damping_factor[1] == 8'h00 && gain_peak[1] == 8'h00)
        else $error("reserved code gave a factor");
    peak_twenty_a: assert property (damping_factor[1] == DF_20 |->
        gain_peak[1] == GP_20) else $error("wrong peak for factor 20");
    peak_low_a: assert property (damping_factor[0] == DF_1P2 |->
        gain_peak[0] == GP_1P2) else $error("wrong peak for factor 1.2");
    wide_bw_a: assert property (damping_factor[1] == DF_20 |->
        $past(loop_bandwidth[1]) == BW_70HZ)
        else $error("factor 20 without 70 Hz");
    not_slow_a: assert property (damping_factor[1] == DF_10 |->
        $past(loop_bandwidth[1]) != BW_18HZ)
        else $error("factor 10 at 18 Hz");
    lf_cause_a: assert property (lowfreq_gain_active[0] |->
        $past(analog_feedback[0] & ref_at_or_below_8k[0]))
        else $error("gain active without its mode");
    lf_gate_a: assert property (!lowfreq_gain_active[0] |->
        lowfreq_gain[0] == 3'h0) else $error("gated gain not zero");
    // Field must reach the output two edges after the access edge
    lf_field_a: assert property (psel && penable && pready && pwrite &&
        paddr == ADDR_FIRST_DAMP |-> ##2 (!lowfreq_gain_active[0] ||
        lowfreq_gain[0] == $past(pwdata[6:4], 2)))
        else $error("gain field not applied");
endmodule
bind pll_damping_gain_config pll_damping_gain_config_checker chk_i (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .loop_bandwidth(loop_bandwidth), .analog_feedback(analog_feedback),
    .ref_at_or_below_8k(ref_at_or_below_8k),
    .damping_factor(damping_factor), .gain_peak(gain_peak),
    .damping_reserved(damping_reserved), .lowfreq_gain(lowfreq_gain),
    .lowfreq_gain_active(lowfreq_gain_active));
`default_nettype wire

// ---- verification/pll_damping_gain_config_test.sv ----
// Self-checking bench for the loop damping configuration block.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/100ps
`default_nettype none
module pll_damping_gain_config_test;
    import pll_damp_pkg::*;
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0][1:0] loop_bandwidth;
    logic [1:0] analog_feedback, ref_at_or_below_8k;
    logic [1:0] damping_reserved, lowfreq_gain_active;
    logic [1:0][7:0] damping_factor, gain_peak;
    logic [1:0][2:0] lowfreq_gain;
    int mismatches, checks_done;

    pll_damping_gain_config dut (.mclk(mclk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .loop_bandwidth(loop_bandwidth), .analog_feedback(analog_feedback),
        .ref_at_or_below_8k(ref_at_or_below_8k),
        .damping_factor(damping_factor), .gain_peak(gain_peak),
        .damping_reserved(damping_reserved), .lowfreq_gain(lowfreq_gain),
        .lowfreq_gain_active(lowfreq_gain_active));

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("checks=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Answer is taken at the edge that samples pready high, then released
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] df(input int c, input int b);
        case (c)
            1: df = DF_1P2;
            2: df = DF_2P5;
            3: df = DF_5;
            4: df = (b == 0) ? DF_5 : DF_10;
            5: df = (b == 0) ? DF_5 : (b == 1) ? DF_10 : DF_20;
            default: df = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] pk(input logic [7:0] f);
        case (f)
            DF_1P2: pk = GP_1P2;
            DF_2P5: pk = GP_2P5;
            DF_5: pk = GP_5;
            DF_10: pk = GP_10;
            DF_20: pk = GP_20;
            default: pk = 8'h00;
        endcase
    endfunction

    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // Reset values, unused bits and an unmapped word
    task automatic t_regs;
        apb(1'b0, ADDR_SECOND_DAMP, 32'h0);
        chk(rd, 32'h13);
        apb(1'b1, ADDR_FIRST_DAMP, 32'hFFFFFFFF);
        apb(1'b0, ADDR_FIRST_DAMP, 32'h0);
        chk(rd, 32'h77);
        apb(1'b0, 12'h1C0, 32'h0);
        chk(err, 32'h1);
    endtask

    // Every code at every bandwidth on the second loop
    task automatic t_table;
        logic [1:0] bws [3] = '{BW_18HZ, BW_35HZ, BW_70HZ};
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, ADDR_SECOND_DAMP, 32'(c));
            for (int b = 0; b < 3; b++) begin
                @(posedge mclk);
                loop_bandwidth[1] <= bws[b];
                settle();
                chk(damping_factor[1], df(c, b));
                chk(gain_peak[1], pk(df(c, b)));
                chk(damping_reserved[1], c == 0 || c > 5);
            end
        end
    endtask

    // Low-frequency gain with and without its enable and mode
    task automatic t_lowfreq;
        apb(1'b1, ADDR_FIRST_DAMP, 32'h51);
        @(posedge mclk);
        analog_feedback <= 2'h1;
        ref_at_or_below_8k <= 2'h1;
        settle();
        chk(lowfreq_gain[0], 32'h5);
        chk(gain_peak[0], GP_1P2);
        chk(damping_factor[0], DF_1P2);
        chk(damping_reserved[0], 32'h0);
        chk(lowfreq_gain_active[1], 32'h0);
        chk(lowfreq_gain[1], 32'h0);
        apb(1'b1, ADDR_FIRST_GAIN, 32'h0);
        settle();
        chk(lowfreq_gain_active[0], 32'h0);
        apb(1'b1, ADDR_FIRST_GAIN, 32'h80);
        settle();
        chk(lowfreq_gain_active[0], 32'h1);
        @(posedge mclk);
        ref_at_or_below_8k <= 2'h0;
        settle();
        chk(lowfreq_gain[0], 32'h0);
    endtask

    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        loop_bandwidth = {BW_35HZ, BW_35HZ};
        {analog_feedback, ref_at_or_below_8k} = '0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        t_regs();
        t_table();
        t_lowfreq();
        conclude();
    end

    // A hang stops the run after about 5000 cycles
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
endmodule
`default_nettype wire
